// File: include/rtv_pkg.sv
// Shared constants and carriers for the reactor trip voting logic.
// Assumes a 250 MHz system clock and a classic Wishbone register bus.
package rtv_pkg;

	// Register byte offsets.
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_CAUSE = 8'h04;
	localparam logic [7:0] ADR_DELAY = 8'h08;

	// Backup circuit delay, counted in millisecond ticks.
	localparam logic [15:0] DELAY_RST = 16'h03E8;
	localparam int TICK_US = 1000;
	localparam int CLK_MHZ = 250;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;

	// Status register field positions.
	localparam int ST_DEMAND = 0;
	localparam int ST_P6 = 1;
	localparam int ST_P7 = 2;
	localparam int ST_P8 = 3;
	localparam int ST_P10 = 4;
	localparam int ST_IR_BYP = 5;
	localparam int ST_SR_BYP = 6;
	localparam int ST_SR_BLK = 7;
	localparam int ST_TURB = 8;
	localparam int ST_BACKUP = 9;

	// Cause register field positions, one per trip function.
	localparam int CB_IR = 0;
	localparam int CB_SR = 1;
	localparam int CB_OT = 2;
	localparam int CB_OP = 3;
	localparam int CB_PLO = 4;
	localparam int CB_PHI = 5;
	localparam int CB_LVL = 6;
	localparam int CB_FLOW = 7;
	localparam int CB_PUMP = 8;
	localparam int CB_BUS = 9;
	localparam int CB_SI = 10;
	localparam int CB_TURB = 11;
	localparam int N_CAUSE = 12;

	// Channel bistable flags, all active high.
	typedef struct packed {
		logic [1:0] ir_high;
		logic [1:0] sr_high;
		logic [1:0] ir_p6;
		logic [3:0] pr_p10;
		logic [3:0] pr_p8;
		logic [1:0] tfs_p7;
		logic [2:0] ot_exc;
		logic [2:0] op_exc;
		logic [2:0] pzr_lo;
		logic [2:0] pzr_hi;
		logic [2:0] pzr_lvl;
		logic [8:0] flow_low;
		logic [2:0] pump_open;
		logic [2:0] bus_uv;
		logic [2:0] bus_uf;
		logic si_act;
		logic [2:0] oil_low;
		logic [3:0] stop_shut;
		logic [8:0] sg_low;
		logic c20;
	} chan_t;

	// Operator commands, all active high.
	typedef struct packed {
		logic ir_byp_req;
		logic sr_byp_req;
		logic sr_rst_a;
		logic sr_rst_b;
	} manual_t;

endpackage

// File: core/sync_bank.sv
// Two-flip-flop synchroniser bank for asynchronous pin inputs.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
`default_nettype none
module sync_bank #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Data.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;

endmodule
`default_nettype wire

// File: core/reactor_trip_voting_logic.sv
// Coincidence voting and permissive logic forming the reactor trip demand.
// Assumes bistable flags and operator commands arrive asynchronously on
// pins, and that a classic Wishbone master reaches the registers.
// How it works
// [R1] Either intermediate range flag trips unless bypassed.
// [R2] Intermediate bypass accepted only at two-of-four high.
// [R3] Three-of-four low cancels intermediate bypass.
// [R4] Either source range flag trips unless bypassed.
// [R5] Source bypass accepted with one intermediate above P-6.
// [R6] Both intermediate below P-6 reinstates source trip.
// [R7] P-10 permissive also blocks the source trip.
// [R8] Below P-10, coincident reinstate commands restore source trip.
// [R9] Two-of-three overtemperature loops trip.
// [R10] Two-of-three overpower loops trip.
// [R11] Two-of-three low pressure trips unless blocked.
// [R12] Low pressure blocked: three-of-four low and both turbine low.
// [R13] Two-of-three high pressure always trips.
// [R14] Two-of-three high level trips unless blocked.
// [R15] Level blocked: three-of-four low or both turbine low.
// [R16] Loop low flow: two loops above P-7, one above P-8.
// [R17] Pump breakers open: two above P-7, one above P-8.
// [R18] Two buses undervoltage or underfrequency above P-7 trip.
// [R19] Safety injection always trips.
// [R20] Turbine trip: two-of-three oil or four stop valves.
// [R21] Turbine trip becomes reactor trip only above 10%.
// [R22] Backup circuit trips turbine after delay above C-20.
// [R23] P-10 sets at two-of-four high, clears three-of-four low.
// [R24] Trip output is energized normally, drops on demand.
// [R25] Loop limit comparisons arrive as ready exceed flags.
// [R26] Inputs synchronised; all trip functions ORed together.
`timescale 1ns/1ps
`default_nettype none
module reactor_trip_voting_logic
	import rtv_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Channel flags and operator commands.
	input wire chan_t chan_i,
	input wire manual_t manual_i,
	// Breaker and turbine outputs.
	output logic trip_hold_o,
	output logic turb_trip_o,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	// Counts of asserted bits in small vote groups.
	function automatic logic [2:0] ones4(input logic [3:0] v);
		ones4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
	endfunction

	function automatic logic [1:0] ones3(input logic [2:0] v);
		ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
	endfunction

	function automatic logic vote23(input logic [2:0] v);
		vote23 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	chan_t ch;
	manual_t man;

	// Every pin input crosses two flip-flops before any vote sees it.
	sync_bank #(.W($bits(chan_t))) u_sync_chan ( // [R26]
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(chan_i),
		.q_o(ch)
	);

	sync_bank #(.W($bits(manual_t))) u_sync_man ( // [R26]
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(manual_i),
		.q_o(man)
	);

	// Power range counts used by the P-7, P-8 and P-10 permissives.
	logic [2:0] pr_hi_cnt;
	logic [2:0] p8_cnt;
	logic pr_two_high;
	logic pr_three_low;
	logic tfs_both_low;
	logic p6;
	logic p7;
	logic p8;

	assign pr_hi_cnt = ones4(ch.pr_p10);
	assign p8_cnt = ones4(ch.pr_p8);
	// Two of four above means at most two below, so set and clear never
	// overlap; between them they cover every count, so the permissive has no hold band.
	assign pr_two_high = (pr_hi_cnt >= 3'd2); // [R23]
	assign pr_three_low = (pr_hi_cnt <= 3'd1); // [R23]
	assign tfs_both_low = ~ch.tfs_p7[0] & ~ch.tfs_p7[1];
	assign p6 = |ch.ir_p6;
	// P-7 is the low power block seen from above: it is on unless both
	// the nuclear and the turbine sides read low.
	assign p7 = ~(pr_three_low & tfs_both_low); // [R12]
	assign p8 = (p8_cnt >= 3'd2);

	// P-10 permissive, registered; its set and clear points leave no count where it holds.
	logic p10_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p10_r <= 1'b0;
		end else if (pr_two_high) begin
			p10_r <= 1'b1; // [R23]
		end else if (pr_three_low) begin
			p10_r <= 1'b0; // [R23]
		end
	end

	// Intermediate range bypass: taken by command only at two-of-four
	// high, dropped automatically at three-of-four low.
	logic ir_byp_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_byp_r <= 1'b0;
		end else if (pr_three_low) begin
			ir_byp_r <= 1'b0; // [R3]
		end else if (man.ir_byp_req && pr_two_high) begin
			ir_byp_r <= 1'b1; // [R2]
		end
	end

	// Source range manual bypass. Reinstatement wins over a standing
	// request so the operator cannot hold the bypass through a fall.
	logic sr_byp_r;
	logic sr_coinc;
	assign sr_coinc = man.sr_rst_a & man.sr_rst_b;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_byp_r <= 1'b0;
		end else if (!p6) begin
			sr_byp_r <= 1'b0; // [R6]
		end else if (sr_coinc && !p10_r) begin
			sr_byp_r <= 1'b0; // [R8]
		end else if (man.sr_byp_req) begin
			sr_byp_r <= 1'b1; // [R5]
		end
	end

	// Source range block while P-10 stands, unless coincidently
	// reinstated after P-10 clears; the override lasts until P-10 sets.
	// The override drops on the same edge that sets P-10, so the block
	// never misses a cycle while the permissive rises.
	logic sr_keep_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_keep_r <= 1'b0;
		end else if (p10_r || pr_two_high) begin
			sr_keep_r <= 1'b0;
		end else if (sr_coinc) begin
			sr_keep_r <= 1'b1; // [R8]
		end
	end

	logic sr_blk;
	assign sr_blk = sr_byp_r | (p10_r & ~sr_keep_r); // [R7]

	// Per loop votes: low flow per loop, low level per steam generator.
	logic [2:0] loop_low;
	logic [2:0] sg_low;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_loop
			assign loop_low[gi] = vote23(ch.flow_low[3*gi +: 3]); // [R16]
			assign sg_low[gi] = vote23(ch.sg_low[3*gi +: 3]); // [R22]
		end
	endgenerate

	logic [2:0] bus_bad;
	assign bus_bad = ch.bus_uv | ch.bus_uf;

	// Individual trip functions.
	logic [N_CAUSE-1:0] fn;
	logic turb_recog;
	// Limit comparisons are done upstream; only the flags are voted.
	assign turb_recog = vote23(ch.oil_low) | (&ch.stop_shut); // [R20]
	always_comb begin
		fn = '0;
		fn[CB_IR] = (|ch.ir_high) & ~ir_byp_r; // [R1]
		fn[CB_SR] = (|ch.sr_high) & ~sr_blk; // [R4]
		fn[CB_OT] = vote23(ch.ot_exc); // [R9] [R25]
		fn[CB_OP] = vote23(ch.op_exc); // [R10] [R25]
		fn[CB_PLO] = vote23(ch.pzr_lo) & p7; // [R11]
		fn[CB_PHI] = vote23(ch.pzr_hi); // [R13]
		fn[CB_LVL] = vote23(ch.pzr_lvl) & ~(pr_three_low | tfs_both_low); // [R14] [R15]
		fn[CB_FLOW] = (p7 & (ones3(loop_low) >= 2'd2)) | (p8 & (|loop_low)); // [R16]
		fn[CB_PUMP] = (p7 & (ones3(ch.pump_open) >= 2'd2)) | (p8 & (|ch.pump_open)); // [R17]
		fn[CB_BUS] = p7 & (ones3(bus_bad) >= 2'd2); // [R18]
		fn[CB_SI] = ch.si_act; // [R19]
		fn[CB_TURB] = turb_recog & p7; // [R21]
	end

	// Registered demand and energized hold output. Reset leaves the
	// output de-energized: an unready device must never hold rods out.
	logic demand_r;
	logic hold_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			demand_r <= 1'b1;
			hold_r <= 1'b0;
		end else begin
			demand_r <= |fn; // [R26]
			hold_r <= ~(|fn); // [R24]
		end
	end
	assign trip_hold_o = hold_r;

	// Millisecond tick divider for the backup circuit delay.
	logic [31:0] div_r;
	logic tick;
	assign tick = (div_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 32'd1;
		end
	end

	// Backup circuit: counts whole ticks while armed and trips the
	// turbine once the programmed delay is reached. Any drop of the
	// arming condition restarts the delay from zero.
	logic [15:0] delay_r;
	logic [15:0] bk_cnt_r;
	logic backup_r;
	logic armed;
	assign armed = ch.c20 & (ones3(sg_low) >= 2'd2); // [R22]
	always_ff @(posedge clk_i) begin
		if (rst_i || !armed) begin
			bk_cnt_r <= '0;
			backup_r <= 1'b0;
		end else if (bk_cnt_r >= delay_r) begin
			backup_r <= 1'b1; // [R22]
		end else if (tick) begin
			bk_cnt_r <= bk_cnt_r + 16'd1;
		end
	end
	assign turb_trip_o = backup_r;

	// Wishbone access decode. The answer comes one cycle after the
	// request; the write lands on the edge where the master sees ack.
	logic ack_r;
	logic req;
	logic wr_now;
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_now = req & wb_we_i & ack_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end
	assign wb_ack_o = ack_r;

	// Status word showing the block's own state.
	logic [31:0] status;
	always_comb begin
		status = '0;
		status[ST_DEMAND] = demand_r;
		status[ST_P6] = p6;
		status[ST_P7] = p7;
		status[ST_P8] = p8;
		status[ST_P10] = p10_r;
		status[ST_IR_BYP] = ir_byp_r;
		status[ST_SR_BYP] = sr_byp_r;
		status[ST_SR_BLK] = sr_blk;
		status[ST_TURB] = turb_recog;
		status[ST_BACKUP] = backup_r;
	end

	// Sticky record of which functions have tripped; writing ones clears.
	// A trip present in the clearing cycle sets the bit again.
	logic [N_CAUSE-1:0] cause_r;
	logic [N_CAUSE-1:0] cause_clr;
	logic [31:0] clr_mask;
	always_comb begin
		clr_mask = '0;
		for (int b = 0; b < 4; b++) begin
			if (wb_sel_i[b]) begin
				clr_mask[8*b +: 8] = wb_dat_i[8*b +: 8];
			end
		end
		if (!(wr_now && wb_adr_i == ADR_CAUSE)) begin
			clr_mask = '0;
		end
	end
	assign cause_clr = clr_mask[N_CAUSE-1:0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_r <= '0;
		end else begin
			cause_r <= (cause_r & ~cause_clr) | fn;
		end
	end

	// Programmable backup delay, byte lanes honoured.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			delay_r <= DELAY_RST;
		end else if (wr_now && wb_adr_i == ADR_DELAY) begin
			if (wb_sel_i[0]) begin
				delay_r[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				delay_r[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// Read data captured in the request cycle; unmapped reads give zero.
	logic [31:0] rdat_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= '0;
		end else if (req && !ack_r) begin
			if (wb_adr_i == ADR_STATUS) begin
				rdat_r <= status;
			end else if (wb_adr_i == ADR_CAUSE) begin
				rdat_r <= {{(32-N_CAUSE){1'b0}}, cause_r};
			end else if (wb_adr_i == ADR_DELAY) begin
				rdat_r <= {16'h0000, delay_r};
			end else begin
				rdat_r <= '0;
			end
		end
	end
	assign wb_dat_o = rdat_r;

endmodule
`default_nettype wire

// File: testbench/rtv_monitor.sv
// Checker for the trip voting block, watching its ports only.
// Assumes it is bound to every instance of the voting block.
`timescale 1ns/1ps
`default_nettype none
module rtv_monitor
	import rtv_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Flags and outputs.
	input wire chan_t chan_i,
	input wire logic trip_hold_o,
	input wire logic turb_trip_o,
	// Bus handshake.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Inputs pass two sync flops and an output flop, so each cause
	// must hold a few samples before the breaker drive may follow.
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence quiet_s;
		(chan_i == '0) [*4];
	endsequence

	chk_quiet_hold: assert property (quiet_s |=> trip_hold_o)
		else $error("breakers dropped with no flag set");
	chk_ir_trip: assert property (((chan_i.ir_high != 0)
		&& (chan_i.pr_p10 == 0)) [*5] |=> !trip_hold_o)
		else $error("intermediate flux did not trip");
	chk_sr_trip: assert property (((chan_i.sr_high != 0)
		&& (chan_i.ir_p6 == 0) && (chan_i.pr_p10 == 0)) [*5]
		|=> !trip_hold_o)
		else $error("source flux did not trip");
	chk_ot_vote: assert property (($countones(chan_i.ot_exc) >= 2) [*3]
		|=> !trip_hold_o)
		else $error("overtemperature vote missed");
	chk_op_vote: assert property (($countones(chan_i.op_exc) >= 2) [*3]
		|=> !trip_hold_o)
		else $error("overpower vote missed");
	chk_phi_vote: assert property (($countones(chan_i.pzr_hi) >= 2) [*3]
		|=> !trip_hold_o)
		else $error("high pressure vote missed");
	chk_si_trip: assert property (chan_i.si_act [*3]
		|=> !trip_hold_o)
		else $error("injection did not trip");
	chk_ack_reply: assert property (req_s |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than a cycle");
	chk_turb_off: assert property ((!chan_i.c20) [*4]
		|=> !turb_trip_o)
		else $error("backup trip without turbine power");
endmodule
bind reactor_trip_voting_logic rtv_monitor u_mon (.clk_i(clk_i),
	.rst_i(rst_i), .chan_i(chan_i), .trip_hold_o(trip_hold_o),
	.turb_trip_o(turb_trip_o), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// File: testbench/plant_model.sv
// Sensor bistables and trip breakers beside the voting block.
// Assumes the bench names the flag pattern each bistable shows.
`timescale 1ns/1ps
`default_nettype none
module plant_model
	import rtv_pkg::*;
(
	// Clock.
	input wire logic clk_i,
	// Wanted pattern and breaker coil drive.
	input wire chan_t want_i,
	input wire logic hold_i,
	// Flags and breaker state.
	output var chan_t chan_o,
	output logic brk_open_o
);
	// Loop limits arrive already compared, one flag per loop, three per loop for low flow and steam generator level.
	always @(posedge clk_i) begin
		chan_o <= want_i;
	end
	// A breaker opens as soon as its coil loses power.
	assign brk_open_o = !hold_i;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the trip voting block.
// Assumes the package, design and checker files compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rtv_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	chan_t want = '0;
	chan_t chan;
	manual_t man = '0;
	logic hold, turb, brk, ack;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = '0;
	logic [31:0] wdat = '0, rdat, rd;
	logic [3:0] sel = 4'hF;
	int error_cnt = 0, n_compared = 0, cyc_n = 0;
	integer seed = 32'h1058;

	always #2 clk_i = ~clk_i;

	plant_model pm (.clk_i(clk_i), .want_i(want), .hold_i(hold),
		.chan_o(chan), .brk_open_o(brk));
	reactor_trip_voting_logic #(.TICK_CYCLES(4)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .chan_i(chan), .manual_i(man),
		.trip_hold_o(hold), .turb_trip_o(turb), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One classic cycle; the request holds until ack is sampled.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hF);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// Flags are held long enough to cross the syncs before judging.
	task automatic apply(input chan_t c, input logic e);
		want <= c;
		repeat (8) @(posedge clk_i);
		chk(brk, e);
	endtask

	// Demand with no bypass ever granted.
	function automatic logic exp_trip(input chan_t c);
		logic lb, p7, p8;
		int nf;
		lb = $countones(c.pr_p10) <= 1;
		p7 = !(lb && c.tfs_p7 == 2'b00);
		p8 = $countones(c.pr_p8) >= 2;
		nf = 0;
		for (int i = 0; i < 3; i++)
			nf += ($countones(c.flow_low[3*i+:3]) >= 2);
		return c.ir_high != 0 || (c.sr_high != 0 && lb)
			|| $countones(c.ot_exc) >= 2 || $countones(c.op_exc) >= 2
			|| (p7 && $countones(c.pzr_lo) >= 2)
			|| $countones(c.pzr_hi) >= 2
			|| (!lb && c.tfs_p7 != 0 && $countones(c.pzr_lvl) >= 2)
			|| (p7 && nf >= 2) || (p8 && nf >= 1)
			|| (p7 && $countones(c.pump_open) >= 2)
			|| (p8 && c.pump_open != 0)
			|| (p7 && $countones(c.bus_uv | c.bus_uf) >= 2)
			|| c.si_act
			|| (p7 && ($countones(c.oil_low) >= 2 || &c.stop_shut));
	endfunction

	// A hang is cut short here and still reaches the verdict.
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		chan_t c;
		logic [95:0] r;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, ADR_DELAY, 32'h0);
		chk(rd, 32'h000003E8);
		c = '0;
		apply(c, 1'b0);
		c.ot_exc = 3'h1;
		apply(c, 1'b0);
		c.pzr_lo = 3'h3;
		apply(c, 1'b0);
		c.tfs_p7 = 2'b01;
		apply(c, 1'b1);
		c = '0;
		c.pzr_lvl = 3'h5;
		c.pr_p10 = 4'hF;
		apply(c, 1'b0);
		c.tfs_p7 = 2'b11;
		apply(c, 1'b1);
		c.pzr_lvl = 3'h0;
		c.flow_low = 9'h0C0;
		apply(c, 1'b0);
		c.pr_p8 = 4'h9;
		apply(c, 1'b1);
		c = '0;
		c.stop_shut = 4'hF;
		apply(c, 1'b0);
		c.tfs_p7 = 2'b10;
		apply(c, 1'b1);
		repeat (150) begin
			r = {$random(seed), $random(seed), $random(seed)};
			repeat (3) r &= {$random(seed), $random(seed), $random(seed)};
			c = r[66:0];
			apply(c, exp_trip(c));
		end
		c = '0;
		c.ir_high = 2'b10;
		c.pr_p10 = 4'h3;
		apply(c, 1'b1);
		man.ir_byp_req <= 1'b1;
		apply(c, 1'b0);
		man.ir_byp_req <= 1'b0;
		c.pr_p10 = 4'h4;
		apply(c, 1'b1);
		man.ir_byp_req <= 1'b1;
		apply(c, 1'b1);
		man.ir_byp_req <= 1'b0;
		c = '0;
		c.sr_high = 2'b01;
		c.pr_p10 = 4'hC;
		apply(c, 1'b0);
		c.pr_p10 = 4'h0;
		c.ir_p6 = 2'b01;
		apply(c, 1'b1);
		man.sr_byp_req <= 1'b1;
		apply(c, 1'b0);
		// Only the first reinstate command stands.
		man <= manual_t'(4'h2);
		apply(c, 1'b0);
		man.sr_rst_b <= 1'b1;
		apply(c, 1'b1);
		// Reinstate commands released, bypass request alone.
		man <= manual_t'(4'h4);
		apply(c, 1'b0);
		c.ir_p6 = 2'b00;
		apply(c, 1'b1);
		man <= '0;
		c = '0;
		c.si_act = 1'b1;
		apply(c, 1'b1);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(rd, 32'h1 << ST_DEMAND);
		c.si_act = 1'b0;
		apply(c, 1'b0);
		wb(1'b0, ADR_CAUSE, 32'h0);
		chk(rd[CB_SI], 1'b1);
		wb(1'b1, ADR_CAUSE, 32'h1 << CB_SI);
		wb(1'b0, ADR_CAUSE, 32'h0);
		chk(rd[CB_SI], 1'b0);
		// With every flag quiet, clearing all bits must leave none set.
		wb(1'b1, ADR_CAUSE, 32'h00000FFF);
		wb(1'b0, ADR_CAUSE, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 8'h40, 32'hFFFFFFFF);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		// Only the low byte lane is enabled; the high byte must keep
		// its reset value.
		wb(1'b1, ADR_DELAY, 32'h0000AB02, 4'h1);
		wb(1'b0, ADR_DELAY, 32'h0);
		chk(rd, {16'h0000, DELAY_RST[15:8], 8'h02});
		wb(1'b1, ADR_DELAY, 32'h2);
		wb(1'b0, ADR_DELAY, 32'h0);
		chk(rd, 32'h2);
		c.c20 = 1'b1;
		c.sg_low = 9'h01B;
		apply(c, 1'b0);
		chk(turb, 1'b0);
		repeat (30) @(posedge clk_i);
		chk(turb, 1'b1);
		c.c20 = 1'b0;
		apply(c, 1'b0);
		chk(turb, 1'b0);
		summarize();
	end
endmodule
`default_nettype wire
